// ===== logic/bsoe_pkg.sv
// Constants, opcodes, register map and state encoding of the sequence opcode executor
package bsoe_pkg;

  // Data and address widths
  localparam int unsigned DW        = 16;
  localparam int unsigned AW        = 16;
  localparam int unsigned RAW       = 4;
  localparam int unsigned NUM_FLAGS = 8;
  localparam int unsigned FLAG_HI   = 8;

  // Timing: clock period and the two time resolutions
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned CYC_PER_US    = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned US_TICK_W     = 5;
  localparam int unsigned FRAME_LSB_US  = 100;
  localparam int unsigned FRAME_PRE_W   = 7;
  localparam int unsigned TT_PRE_W      = 7;

  // Opcodes handled here
  localparam logic [DW-1:0] OP_FLAG_UPDATE       = 16'h000c;
  localparam logic [DW-1:0] OP_LOAD_TIMETAG      = 16'h000d;
  localparam logic [DW-1:0] OP_LOAD_FRAME_TIMER  = 16'h000e;
  localparam logic [DW-1:0] OP_START_FRAME_TIMER = 16'h000f;
  localparam logic [DW-1:0] OP_PUSH_TIMETAG      = 16'h0010;
  localparam logic [DW-1:0] OP_PUSH_BLOCK_STATUS = 16'h0011;
  localparam logic [DW-1:0] OP_PUSH_IMMEDIATE    = 16'h0012;

  // Register indices on the plain register port
  localparam logic [RAW-1:0] REG_CTRL      = 4'h0;
  localparam logic [RAW-1:0] REG_LIST_PTR  = 4'h1;
  localparam logic [RAW-1:0] REG_CONFIG2   = 4'h2;
  localparam logic [RAW-1:0] REG_STATUS    = 4'h3;
  localparam logic [RAW-1:0] REG_GP_FLAGS  = 4'h4;
  localparam logic [RAW-1:0] REG_FRAME_TMR = 4'h5;
  localparam logic [RAW-1:0] REG_FRAME_CNT = 4'h6;
  localparam logic [RAW-1:0] REG_TIME_TAG  = 4'h7;

  // Field positions
  localparam int unsigned CTRL_START_BIT     = 0;
  localparam int unsigned CTRL_STOP_BIT      = 1;
  localparam int unsigned CFG2_RES_LSB       = 7;
  localparam int unsigned CFG2_RES_MSB       = 9;
  localparam int unsigned STAT_BUSY_BIT      = 0;
  localparam int unsigned STAT_BAD_OP_BIT    = 1;
  localparam int unsigned STAT_FRAME_RUN_BIT = 2;

  // Reset values
  localparam logic [AW-1:0]        RST_LIST_PTR = 16'h0000;
  localparam logic [DW-1:0]        RST_CONFIG2  = 16'h0000;
  localparam logic [NUM_FLAGS-1:0] RST_GP_FLAGS = 8'h00;
  localparam logic [DW-1:0]        RST_WORD     = 16'h0000;

  // Fetch and execute sequence, Gray coded along the fetch path
  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_OP_RD   = 3'b001,
    S_OP_CAP  = 3'b011,
    S_PAR_RD  = 3'b010,
    S_PAR_CAP = 3'b110,
    S_EXEC    = 3'b111
  } bsoe_state_e;

endpackage : bsoe_pkg

// ===== logic/bsoe_tick.sv
// Prescaler that turns a stream of enable pulses into one tick every DIV pulses
`timescale 1ns/1ps
`default_nettype none
module bsoe_tick #(
  parameter int unsigned DIV = 20,
  parameter int unsigned W   = 5
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic clr,
  input  wire logic en,
  output logic      tick
);

  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign tick  = en && (cnt_q == LAST);
  assign cnt_d = clr ? '0 : (tick ? '0 : (en ? cnt_q + W'(1) : cnt_q));

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

endmodule // bsoe_tick
`default_nettype wire

// ===== logic/bsoe_flag_update.sv
// Next value of the eight general purpose flags under a flag update parameter
`timescale 1ns/1ps
`default_nettype none
module bsoe_flag_update (
  input  wire logic [bsoe_pkg::NUM_FLAGS-1:0] flags_i,
  input  wire logic [bsoe_pkg::DW-1:0]        par_i,
  output logic      [bsoe_pkg::NUM_FLAGS-1:0] flags_o
);

  genvar n;
  generate
    for (n = 0; n < bsoe_pkg::NUM_FLAGS; n++) begin : g_flag
      logic [1:0] pair;
      assign pair = {par_i[n + bsoe_pkg::FLAG_HI], par_i[n]};
      assign flags_o[n] = (pair == 2'b01) ? 1'b1 :
                          (pair == 2'b10) ? 1'b0 :
                          (pair == 2'b11) ? ~flags_i[n] : flags_i[n];
    end
  endgenerate

endmodule // bsoe_flag_update
`default_nettype wire

// ===== logic/bsoe_exec.sv
// Fetch and execution of the flag, timer and queue push opcodes of the sequence engine
//
// What this block does
// - Flag update acts always, ignoring condition.
// - Flag zero pair: none, set, clear, toggle.
// - Flag n uses bits n and n+8.
// - Load time tag counter from parameter.
// - Load frame timer register from parameter.
// - Start frame counter from frame timer register.
// - Push time tag onto the queue.
// - Push last block status onto the queue.
// - Push parameter word onto the queue.
// - False condition: no action, next instruction.
`timescale 1ns/1ps
`default_nettype none
module bsoe_exec (
  input  wire logic                           ref_clk,
  input  wire logic                           rstn,
  input  wire logic                           ce,
  input  wire logic [bsoe_pkg::RAW-1:0]       reg_addr,
  input  wire logic [bsoe_pkg::DW-1:0]        reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [bsoe_pkg::DW-1:0]        reg_rdata,
  output logic                                mem_rd,
  output logic      [bsoe_pkg::AW-1:0]        mem_addr,
  input  wire logic [bsoe_pkg::DW-1:0]        mem_rdata,
  input  wire logic                           cond_true,
  input  wire logic [bsoe_pkg::DW-1:0]        blk_status,
  output logic                                q_wr,
  output logic      [bsoe_pkg::DW-1:0]        q_data,
  output logic                                ip_adv,
  output logic      [bsoe_pkg::NUM_FLAGS-1:0] gp_flags,
  output logic      [bsoe_pkg::DW-1:0]        time_tag,
  output logic      [bsoe_pkg::DW-1:0]        frame_cnt
);

  bsoe_pkg::bsoe_state_e              state_q;
  logic [bsoe_pkg::AW-1:0]            ip_q;
  logic [bsoe_pkg::DW-1:0]            op_q;
  logic [bsoe_pkg::DW-1:0]            par_q;
  logic                               mem_rd_q;
  logic [bsoe_pkg::AW-1:0]            mem_addr_q;
  logic                               ip_adv_q;
  logic                               bad_op_q;
  logic [bsoe_pkg::NUM_FLAGS-1:0]     gp_q;
  logic [bsoe_pkg::DW-1:0]            cfg2_q;
  logic [bsoe_pkg::DW-1:0]            time_tag_q;
  logic [bsoe_pkg::TT_PRE_W-1:0]      tt_pre_q;
  logic [bsoe_pkg::DW-1:0]            frame_reg_q;
  logic [bsoe_pkg::DW-1:0]            frame_cnt_q;
  logic                               frame_run_q;
  logic                               q_wr_q;
  logic [bsoe_pkg::DW-1:0]            q_data_q;
  logic [bsoe_pkg::DW-1:0]            rdata_q;

  // Register port decode
  wire wr_ctrl   = reg_wr && (reg_addr == bsoe_pkg::REG_CTRL);
  wire wr_ptr    = reg_wr && (reg_addr == bsoe_pkg::REG_LIST_PTR);
  wire wr_cfg2   = reg_wr && (reg_addr == bsoe_pkg::REG_CONFIG2);
  wire wr_status = reg_wr && (reg_addr == bsoe_pkg::REG_STATUS);
  wire wr_gp     = reg_wr && (reg_addr == bsoe_pkg::REG_GP_FLAGS);
  wire start_req = wr_ctrl && reg_wdata[bsoe_pkg::CTRL_START_BIT];
  wire stop_req  = wr_ctrl && reg_wdata[bsoe_pkg::CTRL_STOP_BIT];
  wire bad_clr   = wr_status && reg_wdata[bsoe_pkg::STAT_BAD_OP_BIT];

  // Opcode decode
  wire is_flg = (op_q == bsoe_pkg::OP_FLAG_UPDATE);
  wire is_ltt = (op_q == bsoe_pkg::OP_LOAD_TIMETAG);
  wire is_lft = (op_q == bsoe_pkg::OP_LOAD_FRAME_TIMER);
  wire is_sft = (op_q == bsoe_pkg::OP_START_FRAME_TIMER);
  wire is_ptt = (op_q == bsoe_pkg::OP_PUSH_TIMETAG);
  wire is_pbs = (op_q == bsoe_pkg::OP_PUSH_BLOCK_STATUS);
  wire is_psi = (op_q == bsoe_pkg::OP_PUSH_IMMEDIATE);
  wire is_cond_op = is_ltt || is_lft || is_sft || is_ptt || is_pbs || is_psi;
  wire op_known   = is_flg || is_cond_op;

  // A stop written during execute cancels the instruction
  wire in_exec  = ce && (state_q == bsoe_pkg::S_EXEC) && !stop_req;
  wire exec_flg = in_exec && is_flg;
  wire cond_ok  = in_exec && cond_true;
  wire fire_ltt = cond_ok && is_ltt;
  wire fire_lft = cond_ok && is_lft;
  wire fire_sft = cond_ok && is_sft;
  wire fire_ptt = cond_ok && is_ptt;
  wire fire_pbs = cond_ok && is_pbs;
  wire fire_psi = cond_ok && is_psi;
  wire push_fire = fire_ptt || fire_pbs || fire_psi;
  wire [bsoe_pkg::DW-1:0] push_data = is_ptt ? time_tag_q : (is_pbs ? blk_status : par_q);
  wire bad_set = in_exec && !op_known;

  logic [bsoe_pkg::NUM_FLAGS-1:0] flag_next;
  logic                           us_tick;
  logic                           fr_tick;

  bsoe_flag_update u_flags (
    .flags_i (gp_q),
    .par_i   (par_q),
    .flags_o (flag_next)
  );

  bsoe_tick #(.DIV(bsoe_pkg::CYC_PER_US), .W(bsoe_pkg::US_TICK_W)) u_us_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .clr     (1'b0),
    .en      (1'b1),
    .tick    (us_tick)
  );

  // Restarted on a frame start so the first frame period is a full one
  bsoe_tick #(.DIV(bsoe_pkg::FRAME_LSB_US), .W(bsoe_pkg::FRAME_PRE_W)) u_frame_tick (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .clr     (fire_sft),
    .en      (us_tick && frame_run_q),
    .tick    (fr_tick)
  );

  // Time tag resolution: 2^sel microseconds per count
  wire [2:0] tt_sel = cfg2_q[bsoe_pkg::CFG2_RES_MSB:bsoe_pkg::CFG2_RES_LSB];
  wire [bsoe_pkg::TT_PRE_W-1:0] tt_last = bsoe_pkg::TT_PRE_W'((8'h01 << tt_sel) - 8'h01);
  wire tt_tick = us_tick && (tt_pre_q == tt_last);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q    <= bsoe_pkg::S_IDLE;
      ip_q       <= bsoe_pkg::RST_LIST_PTR;
      op_q       <= bsoe_pkg::RST_WORD;
      par_q      <= bsoe_pkg::RST_WORD;
      mem_rd_q   <= 1'b0;
      mem_addr_q <= bsoe_pkg::RST_LIST_PTR;
      ip_adv_q   <= 1'b0;
    end else if (ce) begin
      mem_rd_q <= 1'b0;
      ip_adv_q <= 1'b0;
      if (stop_req) begin
        state_q <= bsoe_pkg::S_IDLE;
      end else begin
        case (state_q)
          bsoe_pkg::S_IDLE: begin
            if (wr_ptr) begin
              ip_q <= reg_wdata;
            end else if (start_req) begin
              mem_rd_q   <= 1'b1;
              mem_addr_q <= ip_q;
              state_q    <= bsoe_pkg::S_OP_RD;
            end
          end
          bsoe_pkg::S_OP_RD: begin
            state_q <= bsoe_pkg::S_OP_CAP;
          end
          bsoe_pkg::S_OP_CAP: begin
            op_q       <= mem_rdata;
            mem_rd_q   <= 1'b1;
            mem_addr_q <= ip_q + 16'h0001;
            state_q    <= bsoe_pkg::S_PAR_RD;
          end
          bsoe_pkg::S_PAR_RD: begin
            state_q <= bsoe_pkg::S_PAR_CAP;
          end
          bsoe_pkg::S_PAR_CAP: begin
            par_q   <= mem_rdata;
            state_q <= bsoe_pkg::S_EXEC;
          end
          bsoe_pkg::S_EXEC: begin
            // A foreign opcode stops here with the pointer left on it
            if (op_known) begin
              ip_q       <= ip_q + 16'h0002;
              ip_adv_q   <= 1'b1;
              mem_rd_q   <= 1'b1;
              mem_addr_q <= ip_q + 16'h0002;
              state_q    <= bsoe_pkg::S_OP_RD;
            end else begin
              state_q <= bsoe_pkg::S_IDLE;
            end
          end
          default: begin
            state_q <= bsoe_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      gp_q     <= bsoe_pkg::RST_GP_FLAGS;
      cfg2_q   <= bsoe_pkg::RST_CONFIG2;
      bad_op_q <= 1'b0;
    end else if (ce) begin
      if (exec_flg) begin
        gp_q <= flag_next;
      end else if (wr_gp) begin
        gp_q <= reg_wdata[bsoe_pkg::NUM_FLAGS-1:0];
      end
      if (wr_cfg2) begin
        cfg2_q <= reg_wdata;
      end
      bad_op_q <= bad_set || (bad_op_q && !bad_clr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      time_tag_q <= bsoe_pkg::RST_WORD;
      tt_pre_q   <= '0;
    end else if (ce) begin
      if (fire_ltt) begin
        time_tag_q <= par_q;
        tt_pre_q   <= '0;
      end else if (us_tick) begin
        tt_pre_q <= tt_tick ? '0 : tt_pre_q + bsoe_pkg::TT_PRE_W'(1);
        if (tt_tick) begin
          time_tag_q <= time_tag_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_reg_q <= bsoe_pkg::RST_WORD;
      frame_cnt_q <= bsoe_pkg::RST_WORD;
      frame_run_q <= 1'b0;
    end else if (ce) begin
      if (fire_lft) begin
        frame_reg_q <= par_q;
      end
      if (fire_sft) begin
        frame_cnt_q <= frame_reg_q;
        frame_run_q <= (frame_reg_q != bsoe_pkg::RST_WORD);
      end else if (fr_tick) begin
        frame_cnt_q <= frame_cnt_q - 16'h0001;
        frame_run_q <= (frame_cnt_q != 16'h0001);
      end
    end
  end

  // Read mux; unmapped indices read zero
  wire [bsoe_pkg::DW-1:0] status_word = {13'h0000, frame_run_q, bad_op_q, state_q != bsoe_pkg::S_IDLE};
  wire [bsoe_pkg::DW-1:0] rd_mux =
    (reg_addr == bsoe_pkg::REG_LIST_PTR)  ? ip_q :
    (reg_addr == bsoe_pkg::REG_CONFIG2)   ? cfg2_q :
    (reg_addr == bsoe_pkg::REG_STATUS)    ? status_word :
    (reg_addr == bsoe_pkg::REG_GP_FLAGS)  ? {8'h00, gp_q} :
    (reg_addr == bsoe_pkg::REG_FRAME_TMR) ? frame_reg_q :
    (reg_addr == bsoe_pkg::REG_FRAME_CNT) ? frame_cnt_q :
    (reg_addr == bsoe_pkg::REG_TIME_TAG)  ? time_tag_q : bsoe_pkg::RST_WORD;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      q_wr_q   <= 1'b0;
      q_data_q <= bsoe_pkg::RST_WORD;
      rdata_q  <= bsoe_pkg::RST_WORD;
    end else if (ce) begin
      q_wr_q <= push_fire;
      if (push_fire) begin
        q_data_q <= push_data;
      end
      rdata_q <= reg_rd ? rd_mux : bsoe_pkg::RST_WORD;
    end
  end

  assign reg_rdata = rdata_q;
  assign mem_rd    = mem_rd_q;
  assign mem_addr  = mem_addr_q;
  assign q_wr      = q_wr_q;
  assign q_data    = q_data_q;
  assign ip_adv    = ip_adv_q;
  assign gp_flags  = gp_q;
  assign time_tag  = time_tag_q;
  assign frame_cnt = frame_cnt_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_flag_always;
    (exec_flg && !cond_true) |=> (gp_q == $past(flag_next));
  endproperty
  a_flag_always: assert property (p_flag_always) else $error("flag update skipped on false condition");
  property p_flag_zero_toggle;
    (exec_flg && par_q[8] && par_q[0]) |=> (gp_q[0] != $past(gp_q[0]));
  endproperty
  a_flag_zero_toggle: assert property (p_flag_zero_toggle) else $error("flag zero did not toggle");
  property p_flag_set_only;
    (exec_flg && (par_q[15:8] == 8'h00)) |=> (gp_q == ($past(gp_q) | $past(par_q[7:0])));
  endproperty
  a_flag_set_only: assert property (p_flag_set_only) else $error("low bits did not set flags");
  property p_load_timetag;
    fire_ltt |=> (time_tag_q == $past(par_q));
  endproperty
  a_load_timetag: assert property (p_load_timetag) else $error("time tag not loaded");
  property p_load_frame;
    fire_lft |=> (frame_reg_q == $past(par_q));
  endproperty
  a_load_frame: assert property (p_load_frame) else $error("frame timer register not loaded");
  property p_start_frame;
    fire_sft |=> (frame_cnt_q == $past(frame_reg_q)) && (frame_run_q == ($past(frame_reg_q) != 16'h0000));
  endproperty
  a_start_frame: assert property (p_start_frame) else $error("frame counter not started");
  property p_push_timetag;
    fire_ptt |=> q_wr_q && (q_data_q == $past(time_tag_q));
  endproperty
  a_push_timetag: assert property (p_push_timetag) else $error("time tag not pushed");
  property p_push_status;
    fire_pbs |=> q_wr_q && (q_data_q == $past(blk_status));
  endproperty
  a_push_status: assert property (p_push_status) else $error("block status not pushed");
  property p_push_imm;
    fire_psi |=> q_wr_q && (q_data_q == $past(par_q));
  endproperty
  a_push_imm: assert property (p_push_imm) else $error("immediate not pushed");
  property p_false_skip;
    (in_exec && is_cond_op && !cond_true) |=> !q_wr_q && $stable(frame_reg_q) && (state_q == bsoe_pkg::S_OP_RD);
  endproperty
  a_false_skip: assert property (p_false_skip) else $error("action taken on false condition");
  property p_advance;
    (in_exec && op_known) |=> ip_adv_q && mem_rd_q && (ip_q == $past(ip_q) + 16'h0002) && (mem_addr_q == ip_q);
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not skip the pair");
  c_flag_update: cover property (exec_flg);
  c_push_imm:    cover property (fire_psi ##1 q_wr_q);
  c_false_skip:  cover property (in_exec && is_cond_op && !cond_true);
  c_frame_done:  cover property (frame_run_q ##1 !frame_run_q);

endmodule // bsoe_exec
`default_nettype wire

// ===== tb/bsoe_mem_model.sv
// Instruction memory model that holds the list written by the host
`timescale 1ns/1ps
`default_nettype none
module bsoe_mem_model (
  input  wire logic                    ref_clk,
  input  wire logic                    mem_rd,
  input  wire logic [bsoe_pkg::AW-1:0] mem_addr,
  output logic      [bsoe_pkg::DW-1:0] mem_rdata
);
  logic [bsoe_pkg::DW-1:0] words [0:15];
  initial mem_rdata = 16'h0000;
  always @(posedge ref_clk) begin
    if (mem_rd) begin
      mem_rdata <= words[mem_addr[3:0]];
    end else begin
      // Stale data flips every cycle so a late sample is caught
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // bsoe_mem_model
`default_nettype wire

// ===== tb/tb_bc_sequence_opcode_exec.sv
// Self-checking bench of the sequence opcode executor
`timescale 1ns/1ps
`default_nettype none
module tb_bc_sequence_opcode_exec;
  typedef logic [bsoe_pkg::DW-1:0] bsoe_word_t;
  typedef struct packed {
    bsoe_word_t op0, p0, op1, p1;
    logic       cond;
    bsoe_word_t blk;
    logic [7:0] fl_in, fl_exp;
    logic [1:0] nq;
    bsoe_word_t q_exp, fr_exp;
  } bsoe_row_s;
  logic                         ref_clk, rstn, ce, reg_wr, reg_rd, mem_rd, cond_true, q_wr, ip_adv;
  logic [bsoe_pkg::RAW-1:0]     reg_addr;
  bsoe_word_t                   reg_wdata, reg_rdata, mem_addr, mem_rdata, blk_status, q_data;
  bsoe_word_t                   time_tag, frame_cnt, q_last, d;
  logic [bsoe_pkg::NUM_FLAGS-1:0] gp_flags;
  int                           n_errors, checked, nq_seen, nadv;
  bsoe_row_s                    rows [8];

  bsoe_exec dut (.ref_clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mem_rd, .mem_addr, .mem_rdata, .cond_true, .blk_status, .q_wr, .q_data, .ip_adv,
    .gp_flags, .time_tag, .frame_cnt);
  bsoe_mem_model mem (.ref_clk, .mem_rd, .mem_addr, .mem_rdata);

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (q_wr === 1'b1) begin
      nq_seen++;
      q_last = q_data;
    end
    if (ip_adv === 1'b1) nadv++;
  end

  task automatic chk(input string name, input bsoe_word_t seen, input bsoe_word_t exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [bsoe_pkg::RAW-1:0] a, input bsoe_word_t v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [bsoe_pkg::RAW-1:0] a, output bsoe_word_t v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    // Mid-cycle sample, while the read data stand
    @(negedge ref_clk);
    v = reg_rdata;
  endtask

  task automatic rst(input int n);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk("gp_flags", {8'h00, gp_flags}, 16'h0000);
    chk("frame_cnt", frame_cnt, 16'h0000);
    chk("q_data", q_data, 16'h0000);
    chk("time_tag", time_tag, 16'h0000);
    rd(bsoe_pkg::REG_LIST_PTR, d);
    chk("list ptr", d, 16'h0000);
  endtask

  // A foreign opcode at word 4 parks the engine after the pair
  task automatic run(input bsoe_row_s r);
    mem.words[0] = r.op0;
    mem.words[1] = r.p0;
    mem.words[2] = r.op1;
    mem.words[3] = r.p1;
    mem.words[4] = 16'h0000;
    wr(bsoe_pkg::REG_GP_FLAGS, {8'h00, r.fl_in});
    cond_true  <= r.cond;
    blk_status <= r.blk;
    wr(bsoe_pkg::REG_LIST_PTR, 16'h0000);
    nq_seen = 0;
    nadv = 0;
    wr(bsoe_pkg::REG_CTRL, 16'h0001);
    d = 16'h0001;
    for (int i = 0; i < 40 && d[bsoe_pkg::STAT_BUSY_BIT] !== 1'b0; i++) rd(bsoe_pkg::REG_STATUS, d);
    if (d[bsoe_pkg::STAT_BUSY_BIT] !== 1'b0) begin
      n_errors++;
      final_report();
    end
    chk("gp_flags", {8'h00, gp_flags}, {8'h00, r.fl_exp});
    chk("push count", 16'(nq_seen), 16'(r.nq));
    if (r.nq != 2'h0) chk("q_data", q_last, r.q_exp);
    if (r.op0 === bsoe_pkg::OP_LOAD_TIMETAG) chk("time_tag", time_tag, r.q_exp);
    chk("advance count", 16'(nadv), 16'h0002);
    rd(bsoe_pkg::REG_LIST_PTR, d);
    chk("list ptr", d, 16'h0004);
    if (r.op1 === bsoe_pkg::OP_START_FRAME_TIMER) begin
      chk("frame_cnt", frame_cnt, r.fr_exp);
      rd(bsoe_pkg::REG_FRAME_TMR, d);
      chk("frame timer", d, r.fr_exp);
    end
  endtask

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    cond_true = 1'b0;
    blk_status = 16'h0000;
    // Flag rows walk keep, set, clear, toggle across all eight pairs
    rows = '{
      '{bsoe_pkg::OP_FLAG_UPDATE, 16'hccaa, bsoe_pkg::OP_FLAG_UPDATE, 16'h0000, 1'b0, 16'h0000,
        8'h5a, 8'hb2, 2'h0, 16'h0000, 16'h0000},
      '{bsoe_pkg::OP_FLAG_UPDATE, 16'hccaa, bsoe_pkg::OP_FLAG_UPDATE, 16'h0000, 1'b1, 16'h0000,
        8'ha5, 8'h2b, 2'h0, 16'h0000, 16'h0000},
      '{bsoe_pkg::OP_LOAD_TIMETAG, 16'h1234, bsoe_pkg::OP_PUSH_TIMETAG, 16'h0000, 1'b1, 16'h0000,
        8'h00, 8'h00, 2'h1, 16'h1234, 16'h0000},
      '{bsoe_pkg::OP_PUSH_BLOCK_STATUS, 16'h0000, bsoe_pkg::OP_FLAG_UPDATE, 16'h0000, 1'b1, 16'hbeef,
        8'h00, 8'h00, 2'h1, 16'hbeef, 16'h0000},
      '{bsoe_pkg::OP_PUSH_IMMEDIATE, 16'h5a3c, bsoe_pkg::OP_FLAG_UPDATE, 16'h0000, 1'b1, 16'h0000,
        8'h00, 8'h00, 2'h1, 16'h5a3c, 16'h0000},
      '{bsoe_pkg::OP_PUSH_IMMEDIATE, 16'h5a3c, bsoe_pkg::OP_PUSH_BLOCK_STATUS, 16'h0000, 1'b0, 16'hbeef,
        8'h00, 8'h00, 2'h0, 16'h0000, 16'h0000},
      '{bsoe_pkg::OP_LOAD_FRAME_TIMER, 16'h0007, bsoe_pkg::OP_START_FRAME_TIMER, 16'h0000, 1'b1,
        16'h0000, 8'h00, 8'h00, 2'h0, 16'h0000, 16'h0007},
      '{bsoe_pkg::OP_LOAD_FRAME_TIMER, 16'h0003, bsoe_pkg::OP_START_FRAME_TIMER, 16'h0000, 1'b0,
        16'h0000, 8'h00, 8'h00, 2'h0, 16'h0000, 16'h0007}
    };
    rst(6);
    // Slowest time tag rate, so a loaded value holds through a whole row
    wr(bsoe_pkg::REG_CONFIG2, 16'h0380);
    foreach (rows[i]) run(rows[i]);
    // A stop right behind the start cancels the fetch before any execute
    wr(bsoe_pkg::REG_LIST_PTR, 16'h0000);
    wr(bsoe_pkg::REG_CTRL, 16'h0001);
    wr(bsoe_pkg::REG_CTRL, 16'h0002);
    rd(bsoe_pkg::REG_STATUS, d);
    chk("busy after stop", 16'(d[bsoe_pkg::STAT_BUSY_BIT]), 16'h0000);
    rd(bsoe_pkg::REG_LIST_PTR, d);
    chk("list ptr after stop", d, 16'h0000);
    // Foreign opcode left bad_op set; frame counter still running
    rd(bsoe_pkg::REG_STATUS, d);
    chk("status", d, 16'h0006);
    wr(bsoe_pkg::REG_STATUS, 16'h0002);
    rd(bsoe_pkg::REG_STATUS, d);
    chk("status after clear", d, 16'h0004);
    // Clock enable low: a register write is not taken
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(bsoe_pkg::REG_GP_FLAGS, 16'h0055);
    ce <= 1'b1;
    rd(bsoe_pkg::REG_GP_FLAGS, d);
    chk("gp after ce low", d, 16'h0000);
    // Read-only timer register keeps its value, unmapped index reads zero
    wr(bsoe_pkg::REG_FRAME_TMR, 16'h00aa);
    rd(bsoe_pkg::REG_FRAME_TMR, d);
    chk("frame timer ro", d, 16'h0007);
    rd(4'hf, d);
    chk("unmapped", d, 16'h0000);
    rd(bsoe_pkg::REG_CONFIG2, d);
    chk("config2", d, 16'h0380);
    // Second reset in mid-run with timers and flags active
    wr(bsoe_pkg::REG_GP_FLAGS, 16'h00ff);
    rst(1);
    final_report();
  end
endmodule // tb_bc_sequence_opcode_exec
`default_nettype wire
